// file: core/vpm_defines.vh
`ifndef VPM_DEFINES_VH
`define VPM_DEFINES_VH

// measurement and setting widths
`define VPM_VW            16
`define VPM_PW            8
`define VPM_CW            16

// tenth-second tick: 0.1 s at 10 MHz
`define VPM_TICK_NS       100000000
`define VPM_CLK_NS        100
`define VPM_TICK_CYC      (`VPM_TICK_NS / `VPM_CLK_NS)

// percent scale and fixed figures
`define VPM_PCT           32'd100
`define VPM_WIN_LO_PCT    32'd50
`define VPM_WIN_HI_PCT    32'd120
`define VPM_PL_PCT        32'd38
`define VPM_PL_HYST_PCT   32'd45
`define VPM_HYST_PCT      32'd5
`define VPM_PCT2          32'd10000

// reversal trip: 0.1 s of persistence, giving a trip within 0.2 s
`define VPM_REV_DELAY     8'h01

// factory settings, to be driven onto the setting ports
`define VPM_IMB_THR_DEF   8'h0a // RL3
`define VPM_IMB_TST_DEF   8'h07 // RL4
`define VPM_IMB_TRUN_DEF  8'h14 // RL4
`define VPM_PL_T_DEF      8'h1e // RL11
`define VPM_PL_EN_DEF     1'b1 // RL11
`define VPM_REV_EN_DEF    1'b0 // RL14
`define VPM_SEQ_ABC       1'b0 // RL13
`define VPM_SEQ_ACB       1'b1
`define VPM_UV_THR_DEF    8'h55 // RL18
`define VPM_UV_T_DEF      8'h1e // RL19
`define VPM_EN_DEF        1'b0

`endif

// file: core/vpm_delay_timer.v
`include "vpm_defines.vh"

// counts tenth-second ticks while the trip condition holds; any gap restarts it
module vpm_delay_timer (
  input  wire                 clk_in,
  input  wire                 rst_in,
  input  wire                 cond_in,
  input  wire                 tick_in,
  input  wire [`VPM_PW-1:0]   limit_in,
  output wire                 expired_out
);

  reg [`VPM_PW-1:0] count_q;
  reg [`VPM_PW-1:0] count_d;

  always @*
  begin
    count_d = count_q;
    if (!cond_in)
      count_d = {`VPM_PW{1'b0}}; // RL23
    else if (tick_in && (count_q < limit_in))
      count_d = count_q + 8'h01;
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      count_q <= {`VPM_PW{1'b0}};
    else
      count_q <= count_d;
  end

  // a limit changed downward mid-count takes effect at once
  assign expired_out = cond_in && (count_q >= limit_in);

endmodule // vpm_delay_timer

// file: core/vpm_voltage_protect.v
// Function
// RL1 - imbalance warning above warn percent; fault above fault percent for the delay
// RL2 - imbalance uses start delay in start, run delay in run; one timer
// RL3 - imbalance thresholds in whole percent, default ten percent
// RL4 - imbalance delays in tenth seconds, defaults 0.7 s and 2 s
// RL5 - imbalance and undervoltage flags clear five percent of threshold past it
// RL6 - phase loss warning immediately above 38 percent deviation
// RL7 - phase loss fault when above 38 percent for the whole delay
// RL8 - imbalance, loss, reversal only for 50..120 percent average, three-phase, expansion
// RL9 - phase loss evaluated in ready, start or run only
// RL10 - loss indicators name largest-deviation phase; ties set both
// RL11 - phase loss delay tenth seconds, default 3 s; both enabled by default
// RL12 - phase loss clears only after deviation falls by 45 percent hysteresis
// RL13 - reversal fault when observed order differs from selected sequence
// RL14 - reversal has no warning, no delay setting, trips within 0.2 s, default off
// RL15 - each reversal fault increments the wiring fault counter
// RL16 - undervoltage warning as soon as a phase is below warn threshold
// RL17 - undervoltage fault when below fault threshold continuously for the delay
// RL18 - undervoltage thresholds whole percent of nominal, default 85 percent
// RL19 - undervoltage delay in tenth seconds, default 3 s
// RL20 - undervoltage evaluated in ready and run only, never start
// RL21 - fault and warning have independent enables
// RL22 - each phase loss fault increments the phase loss counter
// RL23 - fault timers restart when their condition clears early
// RL24 - outputs held inactive while the function is inactive
`include "vpm_defines.vh"

module vpm_voltage_protect #(
  parameter TICK_CYCLES = `VPM_TICK_CYC
) (
  input  wire                 clk_in,
  input  wire                 rst_in,
  input  wire [`VPM_VW-1:0]   volt_line12_in,
  input  wire [`VPM_VW-1:0]   volt_line23_in,
  input  wire [`VPM_VW-1:0]   volt_line31_in,
  input  wire [`VPM_VW-1:0]   nominal_volt_in,
  input  wire                 expansion_present_in,
  input  wire                 three_phase_in,
  input  wire                 motor_ready_in,
  input  wire                 motor_start_in,
  input  wire                 motor_run_in,
  input  wire                 observed_acb_in,
  input  wire                 imb_fault_en_in,
  input  wire                 imb_warn_en_in,
  input  wire [`VPM_PW-1:0]   imb_warn_threshold_in,
  input  wire [`VPM_PW-1:0]   imb_fault_threshold_in,
  input  wire [`VPM_PW-1:0]   start_fault_delay_in,
  input  wire [`VPM_PW-1:0]   run_fault_delay_in,
  input  wire                 pl_fault_en_in,
  input  wire                 pl_warn_en_in,
  input  wire [`VPM_PW-1:0]   pl_fault_delay_in,
  input  wire                 rev_fault_en_in,
  input  wire                 seq_acb_sel_in,
  input  wire                 uv_fault_en_in,
  input  wire                 uv_warn_en_in,
  input  wire [`VPM_PW-1:0]   uv_warn_threshold_in,
  input  wire [`VPM_PW-1:0]   uv_fault_threshold_in,
  input  wire [`VPM_PW-1:0]   uv_fault_delay_in,
  output reg                  imb_warn_out,
  output reg                  imb_fault_out,
  output reg                  pl_warn_out,
  output reg                  pl_fault_out,
  output reg  [2:0]           worst_phase_indicator_out,
  output reg                  rev_fault_out,
  output reg                  uv_warn_out,
  output reg                  uv_fault_out,
  output reg  [`VPM_CW-1:0]   pl_fault_count_out,
  output reg  [`VPM_CW-1:0]   wiring_fault_count_out
);

  // tenth-second prescaler; every delay setting counts these ticks, so a delay lands
  // within one tick of its setting, depending on the prescaler phase at the start
  reg  [31:0]          presc_q;
  wire                 tick = (presc_q == TICK_CYCLES - 1); // RL4 RL11 RL19

  always @(posedge clk_in)
  begin
    if (rst_in)
      presc_q <= 32'd0;
    else if (tick)
      presc_q <= 32'd0;
    else
      presc_q <= presc_q + 32'd1;
  end

  // average and per-line deviation
  wire [`VPM_VW*3-1:0] volt_vec = {volt_line31_in, volt_line23_in, volt_line12_in};
  wire [17:0]          vsum = {2'b00, volt_line12_in} + {2'b00, volt_line23_in} + {2'b00, volt_line31_in};
  wire [17:0]          vavg18 = vsum / 18'd3;
  wire [31:0]          avg = {14'd0, vavg18};
  wire [31:0]          nom = {16'd0, nominal_volt_in};
  wire [`VPM_VW*3-1:0] dev_vec;
  wire [2:0]           below_uv_warn;
  wire [2:0]           below_uv_fault;
  wire [2:0]           above_uv_warn_clr;
  wire [2:0]           above_uv_fault_clr;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_line
      wire [`VPM_VW-1:0] v = volt_vec[g*`VPM_VW +: `VPM_VW];
      wire [31:0]        v32 = {16'd0, v};
      wire [31:0]        d32 = (v32 > avg) ? (v32 - avg) : (avg - v32);
      assign dev_vec[g*`VPM_VW +: `VPM_VW] = d32[`VPM_VW-1:0];
      // thresholds are whole percent of nominal; both sides are scaled, so no divider
      // undervoltage set below threshold, clear at threshold plus five percent
      assign below_uv_warn[g]  = v32 * `VPM_PCT < {24'd0, uv_warn_threshold_in} * nom; // RL16 RL18
      assign below_uv_fault[g] = v32 * `VPM_PCT < {24'd0, uv_fault_threshold_in} * nom; // RL17
      assign above_uv_warn_clr[g] = v32 * `VPM_PCT * `VPM_PCT >=
        {24'd0, uv_warn_threshold_in} * nom * (`VPM_PCT + `VPM_HYST_PCT); // RL5
      assign above_uv_fault_clr[g] = v32 * `VPM_PCT * `VPM_PCT >=
        {24'd0, uv_fault_threshold_in} * nom * (`VPM_PCT + `VPM_HYST_PCT); // RL5
    end
  endgenerate

  wire [`VPM_VW-1:0] dev0 = dev_vec[`VPM_VW-1:0];
  wire [`VPM_VW-1:0] dev1 = dev_vec[2*`VPM_VW-1:`VPM_VW];
  wire [`VPM_VW-1:0] dev2 = dev_vec[3*`VPM_VW-1:2*`VPM_VW];
  wire [`VPM_VW-1:0] dmax01 = (dev0 > dev1) ? dev0 : dev1;
  wire [`VPM_VW-1:0] dmax = (dmax01 > dev2) ? dmax01 : dev2;
  // exact ties flag every phase that shares the largest deviation
  wire [2:0]         worst = {dev2 == dmax, dev1 == dmax, dev0 == dmax}; // RL10
  wire [31:0]        dm = {16'd0, dmax};

  // activity windows
  wire in_window = (avg * `VPM_PCT >= `VPM_WIN_LO_PCT * nom) &&
                   (avg * `VPM_PCT <= `VPM_WIN_HI_PCT * nom) &&
                   expansion_present_in && three_phase_in; // RL8
  wire rss_state = motor_ready_in || motor_start_in || motor_run_in;
  wire imb_act   = in_window && rss_state; // RL24
  wire pl_act    = in_window && rss_state; // RL9
  wire rev_act   = in_window && rss_state;
  // undervoltage ignores the average window and the motor wiring: it needs the readings and the ready or run state
  wire uv_act    = expansion_present_in && (motor_ready_in || motor_run_in) && !motor_start_in; // RL20

  // imbalance comparisons: deviation in percent of average against threshold
  // whole-percent thresholds; cross-multiplying keeps every compare in integers
  wire imb_w_set = dm * `VPM_PCT > {24'd0, imb_warn_threshold_in} * avg; // RL1 RL3
  wire imb_f_set = dm * `VPM_PCT > {24'd0, imb_fault_threshold_in} * avg; // RL1
  wire imb_w_clr = dm * `VPM_PCT * `VPM_PCT <=
                   {24'd0, imb_warn_threshold_in} * avg * (`VPM_PCT - `VPM_HYST_PCT); // RL5
  wire imb_f_clr = dm * `VPM_PCT * `VPM_PCT <=
                   {24'd0, imb_fault_threshold_in} * avg * (`VPM_PCT - `VPM_HYST_PCT); // RL5

  // phase loss: fixed 38 percent, clears once 45 percent of the set level below it
  // the clear level sits far below the set level, so a wavering loss does not chatter
  wire pl_set = dm * `VPM_PCT > `VPM_PL_PCT * avg; // RL6
  wire pl_clr = dm * `VPM_PCT2 <= `VPM_PL_PCT * (`VPM_PCT - `VPM_PL_HYST_PCT) * avg; // RL12

  wire uv_w_any = |below_uv_warn;
  wire uv_f_any = |below_uv_fault;
  wire uv_w_clr = &above_uv_warn_clr;
  wire uv_f_clr = &above_uv_fault_clr;

  // one imbalance timer serves both delays, so a start-state imbalance carries into run
  wire [`VPM_PW-1:0] imb_limit = motor_start_in ? start_fault_delay_in : run_fault_delay_in; // RL2 RL4
  wire               rev_wrong = (observed_acb_in != seq_acb_sel_in); // RL13
  wire               imb_exp;
  wire               pl_exp;
  wire               rev_exp;
  wire               uv_exp;

  vpm_delay_timer u_imb_tmr (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .cond_in     (imb_act && imb_f_set && imb_fault_en_in),
    .tick_in     (tick),
    .limit_in    (imb_limit),
    .expired_out (imb_exp)
  );

  // timers count only while their fault enable is on, so turning a fault off restarts its delay
  vpm_delay_timer u_pl_tmr (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .cond_in     (pl_act && pl_set && pl_fault_en_in),
    .tick_in     (tick),
    .limit_in    (pl_fault_delay_in), // RL11
    .expired_out (pl_exp)
  );

  // no warning and no delay setting: a fixed one-tick persistence keeps the trip under 0.2 s
  vpm_delay_timer u_rev_tmr (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .cond_in     (rev_act && rev_wrong && rev_fault_en_in),
    .tick_in     (tick),
    .limit_in    (`VPM_REV_DELAY), // RL14
    .expired_out (rev_exp)
  );

  vpm_delay_timer u_uv_tmr (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .cond_in     (uv_act && uv_f_any && uv_fault_en_in),
    .tick_in     (tick),
    .limit_in    (uv_fault_delay_in), // RL19
    .expired_out (uv_exp)
  );

  // flag next states: set wins, hysteresis clears (reversal clears once the order matches), inactive or disabled forces low
  reg imb_w_d;
  reg imb_f_d;
  reg pl_w_d;
  reg pl_f_d;
  reg rev_f_d;
  reg uv_w_d;
  reg uv_f_d;

  always @*
  begin
    imb_w_d = imb_warn_out;
    imb_f_d = imb_fault_out;
    pl_w_d  = pl_warn_out;
    pl_f_d  = pl_fault_out;
    rev_f_d = rev_fault_out;
    uv_w_d  = uv_warn_out;
    uv_f_d  = uv_fault_out;
    if (!imb_act || !imb_warn_en_in) // RL21
      imb_w_d = 1'b0; // RL24
    else if (imb_w_set)
      imb_w_d = 1'b1; // RL1
    else if (imb_w_clr)
      imb_w_d = 1'b0; // RL5
    if (!imb_act || !imb_fault_en_in) // RL21
      imb_f_d = 1'b0; // RL24
    else if (imb_exp)
      imb_f_d = 1'b1; // RL1
    else if (imb_f_clr)
      imb_f_d = 1'b0; // RL5
    if (!pl_act || !pl_warn_en_in) // RL21
      pl_w_d = 1'b0; // RL24
    else if (pl_set)
      pl_w_d = 1'b1; // RL6
    else if (pl_clr)
      pl_w_d = 1'b0; // RL12
    if (!pl_act || !pl_fault_en_in) // RL21
      pl_f_d = 1'b0; // RL24
    else if (pl_exp)
      pl_f_d = 1'b1; // RL7
    else if (pl_clr)
      pl_f_d = 1'b0; // RL12
    if (!rev_act || !rev_fault_en_in)
      rev_f_d = 1'b0; // RL24
    else if (rev_exp)
      rev_f_d = 1'b1; // RL14
    else if (!rev_wrong)
      rev_f_d = 1'b0;
    if (!uv_act || !uv_warn_en_in) // RL21
      uv_w_d = 1'b0; // RL24
    else if (uv_w_any)
      uv_w_d = 1'b1; // RL16
    else if (uv_w_clr)
      uv_w_d = 1'b0; // RL5
    if (!uv_act || !uv_fault_en_in) // RL21
      uv_f_d = 1'b0; // RL24
    else if (uv_exp)
      uv_f_d = 1'b1; // RL17
    else if (uv_f_clr)
      uv_f_d = 1'b0; // RL5
  end

  // counters saturate rather than wrap so a statistic never reads falsely low
  wire [`VPM_CW-1:0] cnt_max = {`VPM_CW{1'b1}};

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      imb_warn_out              <= 1'b0;
      imb_fault_out             <= 1'b0;
      pl_warn_out               <= 1'b0;
      pl_fault_out              <= 1'b0;
      rev_fault_out             <= 1'b0;
      uv_warn_out               <= 1'b0;
      uv_fault_out              <= 1'b0;
      worst_phase_indicator_out <= 3'b000;
      pl_fault_count_out        <= {`VPM_CW{1'b0}};
      wiring_fault_count_out    <= {`VPM_CW{1'b0}};
    end
    else
    begin
      imb_warn_out  <= imb_w_d;
      imb_fault_out <= imb_f_d;
      pl_warn_out   <= pl_w_d;
      pl_fault_out  <= pl_f_d;
      rev_fault_out <= rev_f_d;
      uv_warn_out   <= uv_w_d;
      uv_fault_out  <= uv_f_d;
      if (pl_w_d || pl_f_d)
        worst_phase_indicator_out <= worst; // RL10
      else
        worst_phase_indicator_out <= 3'b000;
      if (pl_f_d && !pl_fault_out && (pl_fault_count_out != cnt_max))
        pl_fault_count_out <= pl_fault_count_out + 16'h0001; // RL22
      if (rev_f_d && !rev_fault_out && (wiring_fault_count_out != cnt_max))
        wiring_fault_count_out <= wiring_fault_count_out + 16'h0001; // RL15
    end
  end

endmodule // vpm_voltage_protect

// file: verification/vpm_monitor.sv
module vpm_monitor (
  input wire        clk_in,
  input wire        rst_in,
  input wire        expansion_present_in,
  input wire        motor_ready_in,
  input wire        motor_start_in,
  input wire        motor_run_in,
  input wire        observed_acb_in,
  input wire        seq_acb_sel_in,
  input wire        rev_fault_en_in,
  input wire        pl_warn_en_in,
  input wire        imb_warn_out,
  input wire        imb_fault_out,
  input wire        pl_warn_out,
  input wire        pl_fault_out,
  input wire [2:0]  worst_phase_indicator_out,
  input wire        rev_fault_out,
  input wire        uv_warn_out,
  input wire        uv_fault_out,
  input wire [15:0] pl_fault_count_out,
  input wire [15:0] wiring_fault_count_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire [6:0] flags = {imb_warn_out, imb_fault_out, pl_warn_out, pl_fault_out, rev_fault_out, uv_warn_out, uv_fault_out};
  property p_idle; !(motor_ready_in || motor_start_in || motor_run_in) |=> flags == 7'h00; endproperty
  a_idle: assert property (p_idle) else $error("flag up while idle");
  property p_noexp; !expansion_present_in |=> flags == 7'h00; endproperty
  a_noexp: assert property (p_noexp) else $error("flag up without expansion");
  property p_uvstart; motor_start_in |=> !uv_warn_out && !uv_fault_out; endproperty
  a_uvstart: assert property (p_uvstart) else $error("undervoltage in start");
  property p_revoff; !rev_fault_en_in |=> !rev_fault_out; endproperty
  a_revoff: assert property (p_revoff) else $error("reversal while disabled");
  property p_revcause; $rose(rev_fault_out) |-> $past(observed_acb_in) != $past(seq_acb_sel_in); endproperty
  a_revcause: assert property (p_revcause) else $error("reversal without mismatch");
  property p_plwen; !pl_warn_en_in |=> !pl_warn_out; endproperty
  a_plwen: assert property (p_plwen) else $error("loss warning while disabled");
  property p_worst; worst_phase_indicator_out != 3'b000 |-> pl_warn_out || pl_fault_out; endproperty
  a_worst: assert property (p_worst) else $error("indicator without loss flag");
  property p_plcnt; $rose(pl_fault_out) |-> pl_fault_count_out == $past(pl_fault_count_out) + 16'h0001; endproperty
  a_plcnt: assert property (p_plcnt) else $error("loss count not stepped");
  property p_wirecnt; $rose(rev_fault_out) |-> wiring_fault_count_out == $past(wiring_fault_count_out) + 16'h0001;
  endproperty
  a_wirecnt: assert property (p_wirecnt) else $error("wiring count not stepped");
  // the reset edge itself clears the count, so skip the cycle after it
  property p_cnthold; !$past(rst_in) && !$rose(pl_fault_out) |-> $stable(pl_fault_count_out); endproperty
  a_cnthold: assert property (p_cnthold) else $error("loss count moved alone");
  c_pl: cover property ($rose(pl_fault_out));
  c_rev: cover property ($rose(rev_fault_out));
  c_uv: cover property ($rose(uv_fault_out));
endmodule // vpm_monitor

// file: verification/vpm_exp_model.sv
module vpm_exp_model (
  input  wire         clk_in,
  input  wire  [15:0] set12_in,
  input  wire  [15:0] set23_in,
  input  wire  [15:0] set31_in,
  output logic [15:0] volt_line12_out = 16'h0000,
  output logic [15:0] volt_line23_out = 16'h0000,
  output logic [15:0] volt_line31_out = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // readings refresh once a clock, so the block sees a cycle of link latency
  always @(posedge clk_in)
  begin
    volt_line12_out <= set12_in;
    volt_line23_out <= set23_in;
    volt_line31_out <= set31_in;
  end
endmodule // vpm_exp_model

// file: verification/test_vpm_voltage_protect.sv
`include "vpm_defines.vh"

module test_vpm_voltage_protect;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, rst_in, expansion_present_in, three_phase_in, motor_ready_in, motor_start_in, motor_run_in;
  logic [15:0] s12, s23, s31, nominal_volt_in;
  wire  [15:0] volt_line12_in, volt_line23_in, volt_line31_in, pl_fault_count_out, wiring_fault_count_out;
  logic        observed_acb_in, seq_acb_sel_in, rev_fault_en_in, pl_fault_en_in, pl_warn_en_in;
  logic        imb_fault_en_in, imb_warn_en_in, uv_fault_en_in, uv_warn_en_in;
  logic [7:0]  imb_warn_threshold_in, imb_fault_threshold_in, start_fault_delay_in, run_fault_delay_in;
  logic [7:0]  pl_fault_delay_in, uv_warn_threshold_in, uv_fault_threshold_in, uv_fault_delay_in;
  wire         imb_warn_out, imb_fault_out, pl_warn_out, pl_fault_out, rev_fault_out, uv_warn_out, uv_fault_out;
  wire  [2:0]  worst_phase_indicator_out;
  wire  [3:0]  flt = {uv_fault_out, rev_fault_out, pl_fault_out, imb_fault_out};
  int          fails, check_count, e_iw, e_pw, e_uw, p12, p23, p31;
  int          hv[9][3] = '{'{400, 400, 480}, '{400, 400, 462}, '{400, 400, 400}, '{150, 400, 400},
                            '{260, 400, 400}, '{290, 400, 400}, '{335, 400, 400}, '{345, 400, 400}, '{360, 400, 400}};

  vpm_exp_model u_vpm_exp_model (.clk_in, .set12_in(s12), .set23_in(s23), .set31_in(s31),
    .volt_line12_out(volt_line12_in), .volt_line23_out(volt_line23_in), .volt_line31_out(volt_line31_in));
  vpm_voltage_protect #(.TICK_CYCLES(10)) u_vpm_voltage_protect (.clk_in, .rst_in, .volt_line12_in,
    .volt_line23_in, .volt_line31_in, .nominal_volt_in, .expansion_present_in, .three_phase_in, .motor_ready_in,
    .motor_start_in, .motor_run_in, .observed_acb_in, .imb_fault_en_in, .imb_warn_en_in, .imb_warn_threshold_in,
    .imb_fault_threshold_in, .start_fault_delay_in, .run_fault_delay_in, .pl_fault_en_in, .pl_warn_en_in,
    .pl_fault_delay_in, .rev_fault_en_in, .seq_acb_sel_in, .uv_fault_en_in, .uv_warn_en_in, .uv_warn_threshold_in,
    .uv_fault_threshold_in, .uv_fault_delay_in, .imb_warn_out, .imb_fault_out, .pl_warn_out, .pl_fault_out,
    .worst_phase_indicator_out, .rev_fault_out, .uv_warn_out, .uv_fault_out, .pl_fault_count_out,
    .wiring_fault_count_out);

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic chk(logic [39:0] seen, logic [39:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  function automatic int dv(int x, int a);
    return x > a ? x - a : a - x;
  endfunction
  function automatic int upd(int old, bit en, bit set, bit clr);
    return !en ? 0 : set ? 1 : clr ? 0 : old;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // reference flags for one settled set of readings; set/hold/clear is idempotent, so that matches per-cycle logic
  task automatic refr(int a12, int a23, int a31);
    int a, m, mn, nm;
    bit act;
    a = (a12 + a23 + a31) / 3;
    m = dv(a12, a) > dv(a23, a) ? dv(a12, a) : dv(a23, a);
    m = dv(a31, a) > m ? dv(a31, a) : m;
    mn = a12 < a23 ? a12 : a23;
    mn = a31 < mn ? a31 : mn;
    nm = nominal_volt_in;
    act = expansion_present_in && three_phase_in && (motor_ready_in || motor_start_in || motor_run_in)
          && a * 100 >= 50 * nm && a * 100 <= 120 * nm;
    e_iw = upd(e_iw, act && imb_warn_en_in, m * 100 > imb_warn_threshold_in * a,
               m * 10000 <= imb_warn_threshold_in * a * 95);
    e_pw = upd(e_pw, act && pl_warn_en_in, m * 100 > 38 * a, m * 10000 <= 2090 * a);
    e_uw = upd(e_uw, expansion_present_in && (motor_ready_in || motor_run_in) && !motor_start_in && uv_warn_en_in,
               mn * 100 < uv_warn_threshold_in * nm, mn * 10000 >= uv_warn_threshold_in * nm * 105);
  endtask
  // the link delays readings a cycle, so new settings meet the old readings for one edge first
  task automatic step(int a12, int a23, int a31);
    {s12, s23, s31} = {16'(a12), 16'(a23), 16'(a31)};
    cyc(3);
    refr(p12, p23, p31);
    refr(a12, a23, a31);
    {p12, p23, p31} = {a12, a23, a31};
    chk(imb_warn_out, e_iw[0]);
    chk(pl_warn_out, e_pw[0]);
    chk(uv_warn_out, e_uw[0]);
  endtask
  task automatic mode(bit r, bit s, bit u);
    {motor_ready_in, motor_start_in, motor_run_in} = {r, s, u};
    cyc(2);
  endtask
  // prescaler phase is unknown, so allow about a tick either side of the limit
  task automatic trip(int k, int lim);
    int n;
    n = 0;
    while (flt[k] !== 1'b1 && n < 10 * lim + 40)
    begin
      cyc(1);
      n++;
    end
    chk(n >= 10 * lim - 14 && n <= 10 * lim + 13, 1'b1);
  endtask

  initial
  begin
    #1000000;
    fails++;
    close_out;
  end

  initial
  begin
    {rst_in, expansion_present_in, three_phase_in, motor_ready_in, motor_start_in, motor_run_in} = 6'b111100;
    {imb_fault_en_in, imb_warn_en_in, uv_fault_en_in, uv_warn_en_in} = {4{`VPM_EN_DEF}};
    {pl_fault_en_in, pl_warn_en_in, rev_fault_en_in} = {`VPM_PL_EN_DEF, `VPM_PL_EN_DEF, `VPM_REV_EN_DEF};
    {observed_acb_in, seq_acb_sel_in} = {`VPM_SEQ_ABC, `VPM_SEQ_ABC};
    {imb_warn_threshold_in, imb_fault_threshold_in} = {`VPM_IMB_THR_DEF, `VPM_IMB_THR_DEF};
    {start_fault_delay_in, run_fault_delay_in, pl_fault_delay_in} = {`VPM_IMB_TST_DEF, `VPM_IMB_TRUN_DEF, `VPM_PL_T_DEF};
    {uv_warn_threshold_in, uv_fault_threshold_in, uv_fault_delay_in} = {`VPM_UV_THR_DEF, `VPM_UV_THR_DEF, `VPM_UV_T_DEF};
    {s12, s23, s31, nominal_volt_in} = {4{16'h0190}};
    {fails, check_count, e_iw, e_pw, e_uw} = '0;
    {p12, p23, p31} = {3{32'd400}};
    void'($urandom(32'h4710068c));
    cyc(20);
    rst_in = 1'b0;
    cyc(1);
    chk({flt, imb_warn_out, pl_warn_out, uv_warn_out, pl_fault_count_out, wiring_fault_count_out}, '0);
    {imb_warn_en_in, uv_warn_en_in, imb_fault_en_in, uv_fault_en_in} = 4'hf;
    {start_fault_delay_in, run_fault_delay_in, pl_fault_delay_in, uv_fault_delay_in} = {4{8'hc8}};
    repeat (30)
    begin
      imb_warn_threshold_in = 8'(3 + $urandom % 13);
      step(250 + $urandom % 300, 250 + $urandom % 300, 250 + $urandom % 300);
    end
    imb_warn_threshold_in = `VPM_IMB_THR_DEF;
    foreach (hv[i]) step(hv[i][0], hv[i][1], hv[i][2]);
    for (int st = 0; st < 4; st++)
    begin
      {motor_ready_in, motor_start_in, motor_run_in} = 3'(8 >> st);
      step(300, 400, 400);
    end
    expansion_present_in = 1'b0;
    step(300, 400, 400);
    expansion_present_in = 1'b1;
    pl_warn_en_in = 1'b0;
    step(100, 700, 400);
    pl_warn_en_in = 1'b1;
    step(100, 700, 400);
    chk(worst_phase_indicator_out, 3'b011);
    step(100, 400, 400);
    chk(worst_phase_indicator_out, 3'b001);
    mode(0, 0, 0);
    pl_fault_delay_in = 8'h03;
    mode(0, 0, 1);
    cyc(13);
    s12 = 16'd400;
    cyc(4);
    s12 = 16'd100;
    trip(1, 3);
    chk(pl_fault_count_out, 16'h0001);
    mode(0, 0, 0);
    {start_fault_delay_in, run_fault_delay_in} = {8'h02, 8'h06};
    s12 = 16'd300;
    mode(0, 1, 0);
    trip(0, 2);
    mode(0, 0, 0);
    mode(0, 0, 1);
    trip(0, 6);
    mode(0, 0, 0);
    uv_fault_delay_in = 8'h02;
    mode(1, 0, 0);
    trip(3, 2);
    mode(0, 0, 0);
    {s12, rev_fault_en_in} = {16'd400, 1'b1};
    mode(1, 0, 0);
    for (int k = 0; k < 2; k++)
    begin
      {seq_acb_sel_in, observed_acb_in} = {k[0], !k[0]};
      trip(2, 1);
      observed_acb_in = k[0];
      cyc(3);
      chk({rev_fault_out, wiring_fault_count_out}, {1'b0, 16'(k + 1)});
    end
    mode(0, 0, 0);
    chk(flt, 4'h0);
    close_out;
  end
endmodule // test_vpm_voltage_protect

bind vpm_voltage_protect vpm_monitor u_vpm_monitor (.clk_in, .rst_in, .expansion_present_in, .motor_ready_in,
  .motor_start_in, .motor_run_in, .observed_acb_in, .seq_acb_sel_in, .rev_fault_en_in, .pl_warn_en_in,
  .imb_warn_out, .imb_fault_out, .pl_warn_out, .pl_fault_out, .worst_phase_indicator_out, .rev_fault_out,
  .uv_warn_out, .uv_fault_out, .pl_fault_count_out, .wiring_fault_count_out);
